// ===== common/cvsr_pkg.sv
/*
  Package for the converter voltage setting registers: subaddresses, field
  positions, reset values, voltage decode constants and the blanking time.
  Assumes a device logic clock of 250 MHz and a register access port that
  delivers already decoded I2C subaddress writes and reads.
*/
package cvsr_pkg;

  // subaddresses of the two configuration registers
  localparam logic [7:0] CVSR_ADDR_BUCK3    = 8'h18;
  localparam logic [7:0] CVSR_ADDR_BUCKBOOST = 8'h19;

  // reset values of the two registers
  localparam logic [7:0] CVSR_RST_BUCK3     = 8'h8c;
  localparam logic [7:0] CVSR_RST_BUCKBOOST = 8'hb2;

  // field positions
  localparam int CVSR_SKIP_BIT  = 7;
  localparam int CVSR_RSVD_BIT  = 6;
  localparam int CVSR_CODE_MSB  = 5;

  // highest legal buck-boost code, codes above are reserved
  localparam logic [5:0] CVSR_BB_CODE_MAX = 6'h34;
  localparam logic [5:0] CVSR_BB_STEP_KNEE = 6'h10;
  localparam logic [5:0] CVSR_B3_STEP_KNEE = 6'h1b;

  // voltage decode in millivolts
  localparam logic [15:0] CVSR_BB_BASE_MV   = 16'h0497; // 1175 mV at code 0
  localparam logic [15:0] CVSR_BB_KNEE_MV   = 16'h0640; // 1600 mV at code 10h
  localparam logic [15:0] CVSR_B3_BASE_MV   = 16'h0384; // 900 mV at code 0
  localparam logic [15:0] CVSR_B3_KNEE_MV   = 16'h0640; // 1600 mV at code 1bh
  localparam logic [15:0] CVSR_FINE_STEP_MV = 16'h0019; // 25 mV
  localparam logic [15:0] CVSR_WIDE_STEP_MV = 16'h0032; // 50 mV

  // monitor blanking time after a write
  localparam int CVSR_CLK_MHZ       = 250;
  localparam int CVSR_BLANK_MS      = 5;
  localparam int CVSR_BLANK_CYCLES  = CVSR_BLANK_MS * 1000 * CVSR_CLK_MHZ;

  // one register write from the access port
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } cvsr_wr_t;

  // settings of one converter as seen by the analog side
  typedef struct packed {
    logic        pulse_skip_enable;
    logic [5:0]  code;
    logic [15:0] millivolts;
    logic        monitor_blank;
  } cvsr_conv_t;

endpackage

// ===== hdl/cvsr_regs.sv
/*
  Holds the third buck and the buck-boost converter configuration registers,
  their voltage decode and the monitor blanking timers started by writes.
  Assumes the I2C slave runs on clk and presents one-cycle write strobes and
  a combinational read address; password state comes from the lock logic.
  The resistor select strap is a pin and is synchronised here.
*/
////////////////////////////////////////////////////////////////////////////////
// How it works
// - The buck-boost register sits at 18h+1 with reset b2h and its low six bits hold the voltage code.
// - A write to either register only lands while the password unlock is present.
// - Each buck-boost register write blanks that converter's voltage supervision for 5 ms.
// - After reset the buck-boost code may be replaced by a default chosen by the resistor select strap.
// - Bit 7 is a read-write pulse-skip enable resetting to one, and bit 6 reads zero.
// - Buck-boost codes 0h to fh step 25 mV from 1.175 V, then 50 mV from 1.600 V up to 3.400 V.
// - Third buck codes 24h to 3fh run from 2.050 V in 50 mV steps to 3.400 V.
// - The third buck register sits at 18h with reset 8ch and the same field layout.
// - Each third buck register write blanks that converter's supervision for 5 ms.
module cvsr_regs #(
  parameter int          BLANK_CYCLES = cvsr_pkg::CVSR_BLANK_CYCLES,
  parameter logic [5:0]  BB_STRAP_CODE = 6'h32
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire cvsr_pkg::cvsr_wr_t   wr,
  input  wire logic                 unlocked,
  input  wire logic [7:0]           rd_addr,
  input  wire logic                 resistor_select_input,
  output      logic [7:0]           rd_data,
  output      logic                 rd_hit,
  output      cvsr_pkg::cvsr_conv_t third_buck,
  output      cvsr_pkg::cvsr_conv_t buckboost
);

  logic [7:0]  b3_q;
  logic [7:0]  bb_q;
  logic        strap_s1_q;
  logic        strap_s2_q;
  logic        strap_done_q;
  logic        wr_b3;
  logic        wr_bb;
  logic [31:0] b3_cnt_q;
  logic [31:0] bb_cnt_q;
  logic [15:0] b3_mv_d;
  logic [15:0] bb_mv_d;

  //////////////////////////////////////////////////////////////////////////////
  // strap synchroniser, the pin is asynchronous to clk
  always_ff @(posedge clk) begin
    strap_s1_q <= resistor_select_input;
    strap_s2_q <= strap_s1_q;
  end

  // writes gated by password state
  assign wr_b3 = wr.valid && unlocked && (wr.addr == cvsr_pkg::CVSR_ADDR_BUCK3);
  assign wr_bb = wr.valid && unlocked && (wr.addr == cvsr_pkg::CVSR_ADDR_BUCKBOOST);

  // third buck register, bit 6 forced low
  always_ff @(posedge clk) begin
    if (rst) begin
      b3_q <= cvsr_pkg::CVSR_RST_BUCK3;
    end else if (wr_b3) begin
      b3_q <= wr.data & 8'hbf;
    end
  end

  // buck-boost register; strap is applied once, after reset release,
  // because a reset flop may only take a constant
  always_ff @(posedge clk) begin
    if (rst) begin
      bb_q         <= cvsr_pkg::CVSR_RST_BUCKBOOST;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (wr_bb) begin
        // reserved codes are host's duty to avoid; stored as written
        bb_q <= wr.data & 8'hbf;
      end else if (!strap_done_q && strap_s2_q) begin
        bb_q[cvsr_pkg::CVSR_CODE_MSB:0] <= BB_STRAP_CODE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // blanking timers, restart on every accepted write
  always_ff @(posedge clk) begin
    if (rst) begin
      b3_cnt_q <= 32'h0;
      bb_cnt_q <= 32'h0;
    end else begin
      if (wr_b3) b3_cnt_q <= 32'(BLANK_CYCLES);
      else if (b3_cnt_q != 32'h0) b3_cnt_q <= b3_cnt_q - 32'h1;
      if (wr_bb) bb_cnt_q <= 32'(BLANK_CYCLES);
      else if (bb_cnt_q != 32'h0) bb_cnt_q <= bb_cnt_q - 32'h1;
    end
  end

  // voltage decode in millivolts
  always_comb begin
    logic [5:0] c3;
    logic [5:0] c4;
    c3 = b3_q[cvsr_pkg::CVSR_CODE_MSB:0];
    c4 = bb_q[cvsr_pkg::CVSR_CODE_MSB:0];
    if (c4 < cvsr_pkg::CVSR_BB_STEP_KNEE)
      bb_mv_d = 16'(cvsr_pkg::CVSR_BB_BASE_MV + cvsr_pkg::CVSR_FINE_STEP_MV * 16'(c4));
    else
      bb_mv_d = 16'(cvsr_pkg::CVSR_BB_KNEE_MV +
                    cvsr_pkg::CVSR_WIDE_STEP_MV * 16'(c4 - cvsr_pkg::CVSR_BB_STEP_KNEE));
    if (c3 < cvsr_pkg::CVSR_B3_STEP_KNEE)
      b3_mv_d = 16'(cvsr_pkg::CVSR_B3_BASE_MV + cvsr_pkg::CVSR_FINE_STEP_MV * 16'(c3));
    else
      b3_mv_d = 16'(cvsr_pkg::CVSR_B3_KNEE_MV +
                    cvsr_pkg::CVSR_WIDE_STEP_MV * 16'(c3 - cvsr_pkg::CVSR_B3_STEP_KNEE));
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs to the analog side; code change only while the
  // converter is off is the host's duty, nothing here blocks it
  always_ff @(posedge clk) begin
    if (rst) begin
      third_buck <= '0;
      buckboost  <= '0;
    end else begin
      third_buck.pulse_skip_enable <= b3_q[cvsr_pkg::CVSR_SKIP_BIT];
      third_buck.code              <= b3_q[cvsr_pkg::CVSR_CODE_MSB:0];
      third_buck.millivolts        <= b3_mv_d;
      third_buck.monitor_blank     <= wr_b3 || (b3_cnt_q > 32'h1);
      buckboost.pulse_skip_enable  <= bb_q[cvsr_pkg::CVSR_SKIP_BIT];
      buckboost.code               <= bb_q[cvsr_pkg::CVSR_CODE_MSB:0];
      buckboost.millivolts         <= bb_mv_d;
      buckboost.monitor_blank      <= wr_bb || (bb_cnt_q > 32'h1);
    end
  end

  // read port, registered; other addresses belong to other blocks
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
      rd_hit  <= 1'b0;
    end else begin
      rd_hit  <= (rd_addr == cvsr_pkg::CVSR_ADDR_BUCK3) || (rd_addr == cvsr_pkg::CVSR_ADDR_BUCKBOOST);
      if (rd_addr == cvsr_pkg::CVSR_ADDR_BUCK3)          rd_data <= b3_q;
      else if (rd_addr == cvsr_pkg::CVSR_ADDR_BUCKBOOST) rd_data <= bb_q;
      else                                               rd_data <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_rsvd_zero;
    @(posedge clk) disable iff (rst) !b3_q[cvsr_pkg::CVSR_RSVD_BIT] && !bb_q[cvsr_pkg::CVSR_RSVD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_locked_write;
    @(posedge clk) disable iff (rst) (wr.valid && !unlocked && !(!strap_done_q && strap_s2_q))
      |=> $stable(bb_q) && $stable(b3_q);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write changed register");

  property p_bb_write;
    @(posedge clk) disable iff (rst) wr_bb |=> bb_q == (($past(wr.data)) & 8'hbf);
  endproperty
  a_bb_write: assert property (p_bb_write) else $error("buck-boost write not stored");

  property p_bb_blank;
    @(posedge clk) disable iff (rst) wr_bb |=> buckboost.monitor_blank;
  endproperty
  a_bb_blank: assert property (p_bb_blank) else $error("no blanking after write");

  property p_b3_blank;
    @(posedge clk) disable iff (rst) wr_b3 |=> third_buck.monitor_blank;
  endproperty
  a_b3_blank: assert property (p_b3_blank) else $error("no third buck blanking");

  property p_bb_volt;
    @(posedge clk) disable iff (rst) (bb_q[5:0] == 6'h34) |=> buckboost.millivolts == 16'h0d48;
  endproperty
  a_bb_volt: assert property (p_bb_volt) else $error("buck-boost decode wrong");

  property p_b3_volt;
    @(posedge clk) disable iff (rst) (b3_q[5:0] == 6'h24) |=> third_buck.millivolts == 16'h0802;
  endproperty
  a_b3_volt: assert property (p_b3_volt) else $error("third buck decode wrong");

  property p_reset_val;
    @(posedge clk) $fell(rst) |-> b3_q == cvsr_pkg::CVSR_RST_BUCK3;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("third buck reset value wrong");

  property p_skip;
    @(posedge clk) disable iff (rst) wr_bb |=> ##1 buckboost.pulse_skip_enable == $past(wr.data[7], 2);
  endproperty
  a_skip: assert property (p_skip) else $error("pulse skip bit wrong");

  property p_b3_write;
    @(posedge clk) disable iff (rst) wr_b3 |=> b3_q == ($past(wr.data) & 8'hbf);
  endproperty
  a_b3_write: assert property (p_b3_write) else $error("third buck write not stored");

  // blanking must drop right after the last counted cycle
  property p_bb_blank_end;
    @(posedge clk) disable iff (rst) (bb_cnt_q == 32'h1) && !wr_bb |=> !buckboost.monitor_blank;
  endproperty
  a_bb_blank_end: assert property (p_bb_blank_end) else $error("buck-boost blanking too long");

  property p_b3_blank_end;
    @(posedge clk) disable iff (rst) (b3_cnt_q == 32'h1) && !wr_b3 |=> !third_buck.monitor_blank;
  endproperty
  a_b3_blank_end: assert property (p_b3_blank_end) else $error("third buck blanking too long");

  property p_rd_bb;
    @(posedge clk) disable iff (rst) (rd_addr == cvsr_pkg::CVSR_ADDR_BUCKBOOST) |=> rd_data == $past(bb_q);
  endproperty
  a_rd_bb: assert property (p_rd_bb) else $error("buck-boost read data wrong");

  property p_strap;
    @(posedge clk) disable iff (rst) (!strap_done_q && strap_s2_q && !wr_bb) |=>
      bb_q[cvsr_pkg::CVSR_CODE_MSB:0] == BB_STRAP_CODE;
  endproperty
  a_strap: assert property (p_strap) else $error("strap code not applied");

  c_bb_write: cover property (@(posedge clk) disable iff (rst) wr_bb);
  c_b3_write: cover property (@(posedge clk) disable iff (rst) wr_b3);
  c_locked:   cover property (@(posedge clk) disable iff (rst) wr.valid && !unlocked);
  c_strap:    cover property (@(posedge clk) disable iff (rst) !strap_done_q && strap_s2_q);

endmodule

// ===== test/cvsr_host.sv
/*
  Host model: drives register writes, the unlock level and the read address.
  Assumes the bench calls its tasks and that clk is the device logic clock.
*/
module cvsr_host (
  input  wire logic               clk,
  input  wire logic [7:0]         rd_data,
  output      cvsr_pkg::cvsr_wr_t wr,
  output      logic               unlocked,
  output      logic [7:0]         rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels at time zero
  initial begin
    wr = '0;
    unlocked = 1'b0;
    rd_addr = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle strobe; released lines show the inverse so stale data never matches
  // callers keep to legal codes and a stopped converter
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic unl);
    @(posedge clk);
    wr <= {1'b1, a, d};
    unlocked <= unl; // unlock level stands with the write
    @(posedge clk);
    wr <= {1'b0, ~a, ~d};
    unlocked <= 1'b0;
  endtask
  // address held; data taken one edge later, sampled mid-cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rd_data;
  endtask
endmodule

// ===== test/cvsr_regs_tb.sv
/*
  Bench for the converter setting registers: reset values, lock, decode,
  reserved bit, blanking and strap. Assumes the host model cvsr_host.
*/
module cvsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         BLANK = 20;
  localparam logic [5:0] STRAP = 6'h21;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 strap_pin = 1'b0;
  cvsr_pkg::cvsr_wr_t   wr;
  logic                 unlocked;
  logic [7:0]           rd_addr;
  logic [7:0]           rd_data;
  logic                 rd_hit;
  cvsr_pkg::cvsr_conv_t third_buck;
  cvsr_pkg::cvsr_conv_t buckboost;
  int                   error_cnt = 0;
  int                   samples_checked = 0;
  logic [7:0]           rv;
  int                   n;
  logic [7:0]           bb_tab [5] = '{8'h40, 8'h8f, 8'h50, 8'he5, 8'h34};
  logic [7:0]           b3_tab [3] = '{8'h64, 8'h30, 8'hff};
  // 250 MHz clock
  always #2 clk = ~clk;
  cvsr_host cvsr_host_inst (.clk(clk), .rd_data(rd_data), .wr(wr), .unlocked(unlocked), .rd_addr(rd_addr));
  cvsr_regs #(.BLANK_CYCLES(BLANK), .BB_STRAP_CODE(STRAP)) cvsr_regs_inst (.clk(clk), .rst(rst), .wr(wr),
    .unlocked(unlocked), .rd_addr(rd_addr), .resistor_select_input(strap_pin), .rd_data(rd_data),
    .rd_hit(rd_hit), .third_buck(third_buck), .buckboost(buckboost));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_mv(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // expected millivolts, buck-boost full range and third buck from code 1bh up only
  function automatic logic [15:0] exp_mv(input logic bb, input logic [5:0] c);
    if (!bb) return 16'(2050 + 50 * (int'(c) - 36));
    return (c < 6'h10) ? 16'(1175 + 25 * int'(c)) : 16'(1600 + 50 * (int'(c) - 16));
  endfunction
  // long reset, then time for the strap synchroniser
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
    cvsr_pkg::cvsr_conv_t c;
    cvsr_host_inst.write_reg(a, d, 1'b1);
    cvsr_host_inst.read_reg(a, rv);
    c = (a == 8'h19) ? buckboost : third_buck;
    chk_byte("readback", d & 8'hbf, rv);
    chk_byte("code", {2'b00, d[5:0]}, {2'b00, c.code});
    chk_byte("skip", {7'h0, d[7]}, {7'h0, c.pulse_skip_enable});
    chk_mv("millivolts", exp_mv(a == 8'h19, d[5:0]), c.millivolts);
  endtask
  // earlier blanking must have ended so only this write is counted
  task automatic blank_len(input logic [7:0] a);
    repeat (BLANK + 5) @(posedge clk);
    cvsr_host_inst.write_reg(a, 8'h32, 1'b1);
    n = 0;
    repeat (BLANK + 10) begin
      @(negedge clk);
      n += int'((a == 8'h19) ? buckboost.monitor_blank : third_buck.monitor_blank);
    end
    chk_byte("blank cycles", 8'(BLANK), 8'(n));
  endtask
  task automatic report_and_stop();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    do_reset();
    cvsr_host_inst.read_reg(8'h19, rv);
    chk_byte("bb reset", 8'hb2, rv);
    chk_byte("bb hit", 8'h01, {7'h0, rd_hit});
    chk_mv("bb reset mv", 16'h0ce4, buckboost.millivolts);
    cvsr_host_inst.read_reg(8'h18, rv);
    chk_byte("b3 reset", 8'h8c, rv);
    cvsr_host_inst.read_reg(8'h1a, rv);
    chk_byte("unmapped", 8'h00, rv | {7'h0, rd_hit});
    cvsr_host_inst.write_reg(8'h19, 8'h05, 1'b0);
    cvsr_host_inst.read_reg(8'h19, rv);
    chk_byte("locked", 8'hb2, rv);
    chk_byte("locked blank", 8'h00, {7'h0, buckboost.monitor_blank});
    cvsr_host_inst.write_reg(8'h18, 8'h05, 1'b0);
    cvsr_host_inst.read_reg(8'h18, rv);
    chk_byte("b3 locked", 8'h8c, rv);
    chk_byte("b3 locked blank", 8'h00, {7'h0, third_buck.monitor_blank});
    foreach (bb_tab[i]) wr_chk(8'h19, bb_tab[i]);
    foreach (b3_tab[i]) wr_chk(8'h18, b3_tab[i]);
    blank_len(8'h19);
    blank_len(8'h18);
    @(posedge clk) strap_pin <= 1'b1;
    do_reset();
    chk_byte("strap code", {2'b00, STRAP}, {2'b00, buckboost.code});
    report_and_stop();
  end
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #40000;
    error_cnt++;
    report_and_stop();
  end
endmodule
